// ==== core/pcsr_pkg.sv ====
// Purpose: Constants for the program sequencer and return stack
// Assumes: 12-bit instruction words, 11-bit program counter by default
// Notes: Opcode patterns are matched against the top bits of the instruction word only
package pcsr_pkg;
	localparam int PC_W_DEF = 11;
	localparam int INSN_W = 12;
	localparam int LIT_W = 8;
	localparam int FADDR_W = 5;
	localparam int PAGE_W = 2;
	// Subroutine call: 1001 kkkk kkkk
	localparam logic [3:0] CALL_OPC = 4'h9;
	localparam int CALL_OPC_LSB = 8;
	// Return with literal: 1000 kkkk kkkk
	localparam logic [3:0] RETL_OPC = 4'h8;
	// Clear file: 0000 011f ffff
	localparam logic [6:0] CLEAR_FILE_OP_OPC = 7'h03;
	localparam int CLEAR_FILE_OP_OPC_LSB = 5;
	// Flag register field positions
	localparam int PAGE_LSB = 5;
	localparam int ZERO_BIT = 2;
	localparam int FLAG_W = 8;
	localparam logic [PAGE_W-1:0] PAGE_RST = 2'h0;
	localparam logic [LIT_W-1:0] W_RST = 8'h00;
	typedef enum logic {PCSR_EXEC, PCSR_FLUSH} pcsr_state_t;
endpackage

// ==== core/pcsr_core.sv ====
// Purpose: Program counter, page select, two-level return stack
// Assumes: i_valid marks one decoded instruction word per cycle
// Notes: Call takes two cycles; the second is a fetch flush

// -----------------------------------------------------------------
// Notes on behaviour
// -----------------------------------------------------------------
module pcsr_core #(
	parameter int PC_W = pcsr_pkg::PC_W_DEF
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Decoder side
	input wire logic i_valid,
	input wire logic [pcsr_pkg::INSN_W-1:0] i_insn,
	input wire logic i_page_wr,
	input wire logic [pcsr_pkg::PAGE_W-1:0] i_page_data,
	// Fetch address and state
	output logic [PC_W-1:0] o_pc,
	output logic [pcsr_pkg::PAGE_W-1:0] o_page_select_bits,
	output logic [PC_W-1:0] o_stack_top,
	output logic [PC_W-1:0] o_stack_lvl2,
	output logic o_busy,
	// Accumulator and file write
	output logic [pcsr_pkg::LIT_W-1:0] o_w,
	output logic o_w_wr,
	output logic o_file_wr,
	output logic [pcsr_pkg::FADDR_W-1:0] o_file_addr,
	output logic [pcsr_pkg::LIT_W-1:0] o_file_data,
	output logic o_zero_set
);
	import pcsr_pkg::*;

	// Refuse widths the page mapping cannot serve
	if (PC_W < 10 || PC_W > 11) begin : g_bad_pc_w
		$error("PC_W must be 10 or 11");
	end

	localparam logic [PC_W-1:0] PC_RST = {PC_W{1'b1}};

	// -------------------------------------------------------------
	// Decode
	// -------------------------------------------------------------
	logic is_call, is_retl, is_clear_file_op, exec;
	logic [PC_W-1:0] pc_inc, call_tgt;
	logic [PC_W-1:0] pc_r, pc_nxt, stk1_r, stk2_r;
	logic [PAGE_W-1:0] page_r;
	pcsr_state_t state_r;
	logic busy_r;
	logic [PAGE_W-1:0] page_hi;

	assign exec = i_valid && (state_r == PCSR_EXEC);
	assign is_call = exec && i_insn[INSN_W-1:CALL_OPC_LSB] == CALL_OPC;
	assign is_retl = exec && i_insn[INSN_W-1:CALL_OPC_LSB] == RETL_OPC;
	assign is_clear_file_op = exec
		&& i_insn[INSN_W-1:CLEAR_FILE_OP_OPC_LSB] == CLEAR_FILE_OP_OPC;
	assign pc_inc = pc_r + 1'b1;
	// Narrow parts drop the top page bit
	assign page_hi = (PC_W == 11) ? page_r : {1'b0, page_r[0]};
	assign call_tgt = PC_W'({page_hi, 1'b0, i_insn[LIT_W-1:0]});

	always_comb begin
		pc_nxt = pc_r;
		if (is_call) begin
			pc_nxt = call_tgt;
		end else if (is_retl) begin
			pc_nxt = stk1_r;
		end else if (exec) begin
			pc_nxt = pc_inc;
		end
	end

	// -------------------------------------------------------------
	// Program counter and flush state
	// -------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pc_r <= PC_RST;
		end else begin
			pc_r <= pc_nxt;
		end
	end

	// Second cycle of a taken branch discards the prefetched word
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_r <= PCSR_EXEC;
			busy_r <= 1'b0;
		end else begin
			case (state_r)
			PCSR_EXEC: begin
				if (is_call || is_retl) begin
					state_r <= PCSR_FLUSH;
					busy_r <= 1'b1;
				end
			end
			PCSR_FLUSH: begin
				if (i_valid) begin
					state_r <= PCSR_EXEC;
					busy_r <= 1'b0;
				end
			end
			default: begin
				state_r <= PCSR_EXEC;
				busy_r <= 1'b0;
			end
			endcase
		end
	end

	// -------------------------------------------------------------
	// Page select bits
	// -------------------------------------------------------------
	// Only an explicit flag write moves them, never a PC carry
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			page_r <= PAGE_RST;
		end else if (i_page_wr) begin
			page_r <= i_page_data;
		end
	end

	// -------------------------------------------------------------
	// Return stack
	// -------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			stk1_r <= '0;
			stk2_r <= '0;
		end else if (is_call) begin
			stk2_r <= stk1_r;
			stk1_r <= pc_inc;
		end else if (is_retl) begin
			stk1_r <= stk2_r;
		end
	end

	// -------------------------------------------------------------
	// Accumulator and file clear
	// -------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_w <= W_RST;
			o_w_wr <= 1'b0;
		end else begin
			o_w_wr <= is_retl;
			if (is_retl)
				o_w <= i_insn[LIT_W-1:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_file_wr <= 1'b0;
			o_file_addr <= '0;
			o_zero_set <= 1'b0;
		end else begin
			o_file_wr <= is_clear_file_op;
			o_zero_set <= is_clear_file_op;
			if (is_clear_file_op)
				o_file_addr <= i_insn[FADDR_W-1:0];
		end
	end

	assign o_file_data = '0;
	assign o_pc = pc_r;
	assign o_page_select_bits = page_r;
	assign o_stack_top = stk1_r;
	assign o_stack_lvl2 = stk2_r;
	// Own flop so the fetch path sees no decode glitch
	assign o_busy = busy_r;

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	a_reset_vector: assert property (@(posedge i_clk)
		i_srst |=> pc_r == PC_RST) else $error("PC not at reset vector");
	a_reset_page: assert property (@(posedge i_clk)
		i_srst |=> page_r == PAGE_RST) else $error("page not cleared");
	a_call_push: assert property (@(posedge i_clk) disable iff (i_srst)
		is_call |=> stk1_r == $past(pc_inc) && stk2_r == $past(stk1_r))
		else $error("call push wrong");
	a_call_target: assert property (@(posedge i_clk) disable iff (i_srst)
		is_call |=> pc_r[LIT_W-1:0] == $past(i_insn[LIT_W-1:0])
		&& pc_r[8] == 1'b0) else $error("call target wrong");
	a_ret_pop: assert property (@(posedge i_clk) disable iff (i_srst)
		is_retl |=> pc_r == $past(stk1_r) && stk1_r == $past(stk2_r)
		&& stk2_r == $past(stk2_r)) else $error("return pop wrong");
	a_ret_literal: assert property (@(posedge i_clk) disable iff (i_srst)
		is_retl |=> o_w_wr && o_w == $past(i_insn[LIT_W-1:0]))
		else $error("literal not loaded");
	a_page_hold: assert property (@(posedge i_clk) disable iff (i_srst)
		!i_page_wr |=> $stable(page_r)) else $error("page moved");
	a_clear_file: assert property (@(posedge i_clk) disable iff (i_srst)
		is_clear_file_op |=> o_file_wr && o_zero_set ##1 o_file_wr == $past(is_clear_file_op))
		else $error("clear file wrong");
	a_clear_addr: assert property (@(posedge i_clk) disable iff (i_srst)
		is_clear_file_op |=> o_file_addr == $past(i_insn[FADDR_W-1:0])
		&& o_file_data == '0) else $error("clear address wrong");
	a_call_page: assert property (@(posedge i_clk) disable iff (i_srst)
		is_call |=> pc_r[PC_W-1:9] == $past(page_hi[PC_W-10:0]))
		else $error("call page wrong");
	a_flush_hold: assert property (@(posedge i_clk) disable iff (i_srst)
		o_busy |=> $stable(pc_r) && $stable(stk1_r) && $stable(stk2_r))
		else $error("flush word executed");
	a_call_flush: assert property (@(posedge i_clk) disable iff (i_srst)
		is_call |=> o_busy) else $error("call not two cycles");
	a_seq_inc: assert property (@(posedge i_clk) disable iff (i_srst)
		exec && !is_call && !is_retl |=> pc_r == $past(pc_inc))
		else $error("PC did not advance");
endmodule

// ==== test/pcsr_fetch_model.sv ====
// Purpose: Fetch path model feeding words to the sequencer
// Assumes: Bench raises i_req with a word just after an edge
// Notes: Idle bus shows the inverse of the last word, never a copy
module pcsr_fetch_model (
	// Clock
	input wire logic i_clk,
	// Bench request
	input wire logic i_req,
	input wire logic [pcsr_pkg::INSN_W-1:0] i_word,
	// Sequencer side
	output logic o_valid,
	output logic [pcsr_pkg::INSN_W-1:0] o_insn
);
	import pcsr_pkg::*;
	logic [INSN_W-1:0] last_r = 12'h000;
	always_ff @(posedge i_clk) begin
		if (i_req) begin
			last_r <= i_word;
		end
	end
	assign o_valid = i_req;
	// Stale data would hide a missing valid check in the sequencer
	assign o_insn = i_req ? i_word : ~last_r;
endmodule

// ==== test/tb.sv ====
// Purpose: Self-checking bench for the program sequencer
// Assumes: PC_W of 11, one check half a cycle after each taken word
// Notes: Flush words carry random junk to prove they are dropped
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pcsr_pkg::*;
	typedef struct packed {
		logic [10:0] pc, s1, s2;
		logic [1:0] pg;
		logic [7:0] w;
		logic [4:0] fa;
		logic zs, wr, bsy;
	} pcsr_exp_t;
	logic i_clk = 0, i_srst = 1, req = 0, i_page_wr = 0, tk = 0;
	logic [11:0] word = 12'h000, i_insn;
	logic [1:0] i_page_data = 2'h0, o_page_select_bits;
	logic [10:0] o_pc, o_stack_top, o_stack_lvl2;
	logic [7:0] o_w, o_file_data;
	logic [4:0] o_file_addr;
	logic i_valid, o_busy, o_w_wr, o_file_wr, o_zero_set;
	pcsr_exp_t q[$], e, m;
	int err_total = 0, checked = 0, cyc = 0, seed = 21979;
	logic [31:0] r;
	pcsr_fetch_model fm_u (.i_clk, .i_req(req), .i_word(word),
		.o_valid(i_valid), .o_insn(i_insn));
	pcsr_core #(.PC_W(11)) dut_u (.i_clk, .i_srst, .i_valid, .i_insn,
		.i_page_wr, .i_page_data, .o_pc, .o_page_select_bits,
		.o_stack_top, .o_stack_lvl2, .o_busy, .o_w, .o_w_wr, .o_file_wr,
		.o_file_addr, .o_file_data, .o_zero_set);
	always #5 i_clk = ~i_clk;
	task automatic chk(input logic [10:0] got, exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("checked %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			finish_test;
		end
	end
	always @(posedge i_clk) tk <= i_valid && !o_busy && !i_srst;
	always @(negedge i_clk) if (tk) begin
		m = q.pop_front();
		chk(o_pc, m.pc);
		chk(o_stack_top, m.s1);
		chk(o_stack_lvl2, m.s2);
		chk(o_page_select_bits, m.pg);
		chk(o_w, m.w);
		chk(o_w_wr, m.wr);
		chk(o_busy, m.bsy);
		chk(o_zero_set, m.zs);
		chk(o_file_wr, m.zs);
		if (m.zs) chk(o_file_addr, m.fa);
		if (m.zs) chk(o_file_data, 11'h000);
	end
	task automatic rst;
		i_srst <= 1;
		repeat (5) @(posedge i_clk);
		i_srst <= 0;
		e = '0;
		e.pc = '1;
		@(negedge i_clk);
		chk(o_pc, e.pc);
		chk(o_page_select_bits, e.pg);
		@(posedge i_clk);
		$display("reset test done");
	endtask
	task automatic page(input logic [1:0] p);
		i_page_wr <= 1;
		i_page_data <= p;
		@(posedge i_clk);
		i_page_wr <= 0;
		e.pg = p;
	endtask
	task automatic op(input logic [11:0] ins);
		logic [1:0] gap;
		e.zs = 0;
		e.wr = 0;
		e.bsy = ins[11:9] == 3'h4;
		if (ins[11:8] == CALL_OPC) begin
			e.s2 = e.s1;
			e.s1 = e.pc + 11'h001;
			e.pc = {e.pg, 1'b0, ins[7:0]};
		end else if (ins[11:8] == RETL_OPC) begin
			e.pc = e.s1;
			e.s1 = e.s2;
			e.w = ins[7:0];
			e.wr = 1;
		end else begin
			e.pc = e.pc + 11'h001;
			e.zs = ins[11:5] == CLEAR_FILE_OP_OPC;
			e.fa = ins[4:0];
		end
		q.push_back(e);
		req <= 1;
		word <= ins;
		@(posedge i_clk);
		// Flush cycle needs a valid word; junk must be ignored
		if (e.bsy) word <= 12'($random(seed));
		if (e.bsy) @(posedge i_clk);
		req <= 0;
		gap = 2'($random(seed));
		// At least one idle edge so req is never set twice in a step
		repeat (int'(gap) + 1) @(posedge i_clk);
	endtask
	initial begin
		rst;
		op(12'h000);
		page(2'h3);
		op(12'h9FF);
		op(12'h000);
		repeat (3) op({CALL_OPC, 8'($random(seed))});
		page(2'h1);
		repeat (3) op({RETL_OPC, 8'($random(seed))});
		op(12'h07F);
		op(12'h900);
		$display("directed test done");
		repeat (40) begin
			r = $random(seed);
			if (r[10]) page(r[12:11]);
			case (r[9:8])
				2'h0: op({CALL_OPC, r[7:0]});
				2'h1: op({RETL_OPC, r[7:0]});
				2'h2: op({CLEAR_FILE_OP_OPC, r[4:0]});
				default: op(12'h000);
			endcase
		end
		$display("random test done");
		page(2'h2);
		rst;
		op(12'h000);
		finish_test;
	end
endmodule
